/* File: design/dpc_pll_host.sv */
`timescale 1ns/1ns
module dpc_pll_host
  import dpc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic start,
  input wire logic stop,
  input wire logic [2:0] prediv_code,
  input wire logic [1:0] vco_postdivider_code,
  input wire logic [7:0] feedback_loop_ratio,
  input wire logic [1:0] vco_band,
  input wire logic irq_lock_en,
  input wire logic irq_lost_en,
  output logic busy,
  output logic ready,
  output logic cal_done,
  output logic fail,
  output logic cfg_error,
  output logic [7:0] pll_status,
  output logic [1:0] irq_events,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_sdo,
  input wire logic spi_sdi,
  input wire logic irq_n
);
  typedef enum {
    S_IDLE, S_CFG, S_GAP, S_POLL, S_RECAL0, S_RECAL1, S_READY,
    S_IRQ_RD, S_IRQ_CLR, S_OFF, S_FAIL
  } dpc_state_type;

  typedef struct packed {
    dpc_state_type st;
    logic pend;
    logic req;
    logic rd;
    logic [14:0] addr;
    logic [7:0] wdata;
    logic [4:0] step;
    logic [7:0] gap;
    logic [7:0] polls;
    logic [2:0] pre;
    logic [1:0] post;
    logic [7:0] ratio;
    logic [1:0] band;
    logic [1:0] irq_en;
    logic [7:0] status;
    logic [1:0] events;
    logic cfg_err;
    logic irq_m;
    logic irq_s;
  } dpc_host_type;

  dpc_host_type q, d;
  dpc_spi_if spi ();

  // address and data of one configuration step
  function automatic logic [22:0] step_word(input dpc_host_type c);
    logic [22:0] w;
    w = {ADDR_PLL_CONTROL, CTL_ENABLE};
    if (c.step < 5'(FIX_N))
      w = {FIX_ADDR[c.step[3:0]], FIX_DATA[c.step[3:0]]};
    else
      case (c.step)
        5'd13: w = {ADDR_POSTDIV_SELECT, 6'h00, c.post};
        5'd14: w = {ADDR_FEEDBACK_RATIO, c.ratio};
        5'd15: w = {ADDR_PREDIV_SELECT, 5'h00, c.pre};
        5'd16: w = {ADDR_VCO_CTL_A, VCO_A[c.band]};
        5'd17: w = {ADDR_VCO_CTL_B, VCO_B[c.band]};
        5'd18: w = {ADDR_VCO_CTL_C, VCO_C[c.band]};
        5'd19: w = {ADDR_IRQ_ENABLE, 2'b00, c.irq_en, 4'h0};
        default: w = {ADDR_PLL_CONTROL, CTL_ENABLE};
      endcase
    return w;
  endfunction : step_word

  // start a serial access unless one is already outstanding
  function automatic dpc_host_type issue(input dpc_host_type c,
    input logic rd, input logic [14:0] addr, input logic [7:0] data);
    dpc_host_type r;
    r = c;
    if (!c.pend)
    begin
      r.req = 1'b1;
      r.pend = 1'b1;
      r.rd = rd;
      r.addr = addr;
      r.wdata = data;
    end
    return r;
  endfunction : issue

  logic [22:0] cfg_word;
  assign cfg_word = step_word(q);

  always_comb
  begin
    d = q;
    d.req = 1'b0;
    d.irq_m = irq_n;
    d.irq_s = q.irq_m;
    if (spi.ack)
      d.pend = 1'b0;
    case (q.st)
      S_IDLE:
        if (start)
        begin
          d.cfg_err = feedback_loop_ratio < RATIO_MIN
            || feedback_loop_ratio > RATIO_MAX
            || prediv_code > PREDIV_CODE_MAX
            || vco_postdivider_code < POSTDIV_CODE_MIN
            || vco_band > VCO_BAND_MAX;
          d.pre = prediv_code;
          d.post = vco_postdivider_code;
          d.ratio = feedback_loop_ratio;
          d.band = vco_band;
          d.irq_en = {irq_lost_en, irq_lock_en};
          d.step = 5'd0;
          d.status = 8'h00;
          d.events = 2'b00;
          if (!d.cfg_err)
            d.st = S_CFG;
        end
      S_CFG:
        // enable only after every setting is written
        if (spi.ack)
        begin
          if (q.step == STEP_LAST)
          begin
            d.st = S_GAP;
            d.gap = POLL_GAP_CYC;
            d.polls = 8'd0;
          end
          else
            d.step = q.step + 5'd1;
        end
        else
          d = issue(d, 1'b0, cfg_word[22:8], cfg_word[7:0]);
      S_GAP:
        if (q.gap == 8'd0)
          d.st = S_POLL;
        else
          d.gap = q.gap - 8'd1;
      S_POLL:
        if (spi.ack)
        begin
          d.status = spi.rdata;
          d.polls = q.polls + 8'd1;
          d.gap = POLL_GAP_CYC;
          if (spi.rdata[ST_UPPER_EDGE] || spi.rdata[ST_LOWER_EDGE])
            d.st = S_RECAL0;
          else if (spi.rdata[ST_CAL_DONE] && spi.rdata[ST_LOCK])
            d.st = S_READY;
          else if (d.polls == POLL_LIMIT)
            d.st = S_FAIL;
          else
            d.st = S_GAP;
        end
        else
          d = issue(d, 1'b1, ADDR_PLL_STATUS, 8'h00);
      S_RECAL0:
        if (spi.ack)
          d.st = S_RECAL1;
        else
          d = issue(d, 1'b0, ADDR_PLL_CONTROL, CTL_ENABLE);
      S_RECAL1:
        if (spi.ack)
          d.st = S_GAP;
        else
          d = issue(d, 1'b0, ADDR_PLL_CONTROL, CTL_ENABLE | CTL_RECAL);
      S_READY:
        if (stop)
          d.st = S_OFF;
        // irq pin low means a latched source
        else if (!q.irq_s)
          d.st = S_IRQ_RD;
      S_IRQ_RD:
        if (spi.ack)
        begin
          d.events = {spi.rdata[IRQ_LOST_BIT], spi.rdata[IRQ_LOCK_BIT]};
          d.st = S_IRQ_CLR;
        end
        else
          d = issue(d, 1'b1, ADDR_IRQ_STATUS_CLEAR, 8'h00);
      S_IRQ_CLR:
        if (spi.ack)
        begin
          d.st = S_GAP;
          d.gap = POLL_GAP_CYC;
          d.polls = 8'd0;
        end
        else
          d = issue(d, 1'b0, ADDR_IRQ_STATUS_CLEAR,
            {2'b00, q.events, 4'h0});
      S_OFF:
        if (spi.ack)
        begin
          // mirror cleared with the pll off
          d.status = 8'h00;
          d.st = S_IDLE;
        end
        else
          d = issue(d, 1'b0, ADDR_PLL_CONTROL, CTL_OFF);
      S_FAIL:
        if (stop)
          d.st = S_OFF;
      default:
        d.st = S_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.st <= S_IDLE;
      q.irq_m <= 1'b1;
      q.irq_s <= 1'b1;
    end
    else if (clk_en)
      q <= d;
  end

  assign spi.req = q.req;
  assign spi.rd = q.rd;
  assign spi.addr = q.addr;
  assign spi.wdata = q.wdata;

  dpc_spi_engine u_engine (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .bus(spi),
    .spi_sdi(spi_sdi),
    .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n),
    .spi_sdo(spi_sdo)
  );

  assign busy = q.st != S_IDLE && q.st != S_READY && q.st != S_FAIL;
  assign ready = q.st == S_READY;
  assign fail = q.st == S_FAIL;
  assign cal_done = q.status[ST_CAL_DONE];
  assign cfg_error = q.cfg_err;
  assign pll_status = q.status;
  assign irq_events = q.events;
endmodule : dpc_pll_host

/* File: pkg/dpc_pkg.sv */
package dpc_pkg;
  localparam int CLK_MHZ = 25;
  // register addresses of the device, 15-bit serial port space
  localparam logic [14:0] ADDR_IRQ_ENABLE = 15'h001f;
  localparam logic [14:0] ADDR_IRQ_STATUS_CLEAR = 15'h0023;
  localparam logic [14:0] ADDR_PLL_CONTROL = 15'h0083;
  localparam logic [14:0] ADDR_PLL_STATUS = 15'h0084;
  localparam logic [14:0] ADDR_FEEDBACK_RATIO = 15'h0085;
  localparam logic [14:0] ADDR_CHARGE_PUMP = 15'h008a;
  localparam logic [14:0] ADDR_POSTDIV_SELECT = 15'h008b;
  localparam logic [14:0] ADDR_PREDIV_SELECT = 15'h008c;
  localparam logic [14:0] ADDR_VCO_CTL_A = 15'h01b5;
  localparam logic [14:0] ADDR_VCO_CTL_B = 15'h01bb;
  localparam logic [14:0] ADDR_VCO_CTL_C = 15'h01c5;
  // fixed setup writes: loop filter, charge pump, regulator, vco
  localparam int FIX_N = 13;
  localparam logic [0:FIX_N-1][14:0] FIX_ADDR = {
    15'h0087, 15'h0088, 15'h0089, ADDR_CHARGE_PUMP, 15'h008d, 15'h01b0,
    15'h01b9, 15'h01bc, 15'h01be, 15'h01bf, 15'h01c0, 15'h01c1, 15'h01c4};
  localparam logic [0:FIX_N-1][7:0] FIX_DATA = {
    8'h62, 8'hc9, 8'h0e, 8'h12, 8'h7b, 8'h00,
    8'h24, 8'h0d, 8'h02, 8'h8e, 8'h2a, 8'h2a, 8'h7e};
  // vco lookup rows: band 0 below 6.3 GHz, 1 up to 7.25 GHz, 2 above
  localparam logic [0:2][7:0] VCO_A = {8'h08, 8'h09, 8'h09};
  localparam logic [0:2][7:0] VCO_B = {8'h03, 8'h03, 8'h13};
  localparam logic [0:2][7:0] VCO_C = {8'h07, 8'h06, 8'h06};
  localparam logic [1:0] VCO_BAND_MAX = 2'h2;
  // control and status fields
  localparam logic [7:0] CTL_ENABLE = 8'h10;
  localparam logic [7:0] CTL_RECAL = 8'h80;
  localparam logic [7:0] CTL_OFF = 8'h00;
  localparam int ST_UPPER_EDGE = 7;
  localparam int ST_LOWER_EDGE = 6;
  localparam int ST_CAL_DONE = 5;
  localparam int ST_LOCK = 1;
  localparam int IRQ_LOCK_BIT = 4;
  localparam int IRQ_LOST_BIT = 5;
  // programming limits
  localparam logic [7:0] RATIO_MIN = 8'h06;
  localparam logic [7:0] RATIO_MAX = 8'h7f;
  localparam logic [2:0] PREDIV_CODE_MAX = 3'h4;
  localparam logic [1:0] POSTDIV_CODE_MIN = 2'h1;
  // index of the last configuration step: fixed, post, ratio, pre, 3 vco, irq, enable
  localparam logic [4:0] STEP_LAST = 5'd20;
  // serial frame and timing
  localparam logic [4:0] FRAME_LAST = 5'd23;
  localparam logic [1:0] HALF_LAST = 2'h3;
  localparam int POLL_GAP_US = 2;
  localparam logic [7:0] POLL_GAP_CYC = 8'(POLL_GAP_US * CLK_MHZ);
  localparam logic [7:0] POLL_LIMIT = 8'd200;
endpackage : dpc_pkg

/* File: pkg/dpc_spi_if.sv */
`timescale 1ns/1ns
interface dpc_spi_if;
  logic req;
  logic rd;
  logic [14:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;
  modport ctrl (output req, rd, addr, wdata, input rdata, ack);
  modport engine (input req, rd, addr, wdata, output rdata, ack);
endinterface : dpc_spi_if

/* File: design/dpc_spi_engine.sv */
`timescale 1ns/1ns
module dpc_spi_engine
  import dpc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  dpc_spi_if.engine bus,
  input wire logic spi_sdi,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_sdo
);
  typedef struct packed {
    logic busy;
    logic sclk;
    logic [1:0] div;
    logic [4:0] nbit;
    logic [23:0] sh;
    logic [7:0] rdata;
    logic ack;
    logic sdi_m;
    logic sdi_s;
  } dpc_eng_type;

  dpc_eng_type q, d;

  always_comb
  begin
    d = q;
    d.ack = 1'b0;
    d.sdi_m = spi_sdi;
    d.sdi_s = q.sdi_m;
    if (!q.busy)
    begin
      if (bus.req)
      begin
        d.busy = 1'b1;
        d.sh = {bus.rd, bus.addr, bus.wdata};
        d.nbit = 5'd0;
        d.div = 2'h0;
        d.sclk = 1'b0;
      end
    end
    else
    begin
      d.div = q.div + 2'h1;
      if (q.div == HALF_LAST)
      begin
        d.div = 2'h0;
        if (!q.sclk)
          d.sclk = 1'b1;
        else
        begin
          // sample late in the high phase, shift on the falling edge
          d.sclk = 1'b0;
          d.sh = {q.sh[22:0], q.sdi_s};
          if (q.nbit == FRAME_LAST)
          begin
            d.busy = 1'b0;
            d.ack = 1'b1;
            d.rdata = {q.sh[6:0], q.sdi_s};
          end
          else
            d.nbit = q.nbit + 5'd1;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else if (clk_en)
      q <= d;
  end

  assign spi_sclk = q.sclk;
  assign spi_cs_n = !q.busy;
  assign spi_sdo = q.sh[23];
  assign bus.ack = q.ack;
  assign bus.rdata = q.rdata;
endmodule : dpc_spi_engine

/* File: verif/dpc_pll_host_assertions.sv */
`timescale 1ns/1ns
module dpc_chk
  import dpc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic start,
  input wire logic [2:0] prediv_code,
  input wire logic [1:0] vco_postdivider_code,
  input wire logic [7:0] feedback_loop_ratio,
  input wire logic [1:0] vco_band,
  input wire logic busy,
  input wire logic ready,
  input wire logic fail,
  input wire logic cfg_error,
  input wire logic cal_done,
  input wire logic [7:0] pll_status,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdo
);
  logic go, bad, sk_q;
  logic [4:0] n_q;
  assign go = start && clk_en && !busy && !ready && !fail;
  assign bad = feedback_loop_ratio < RATIO_MIN ||
    feedback_loop_ratio > RATIO_MAX || prediv_code > PREDIV_CODE_MAX ||
    vco_postdivider_code < POSTDIV_CODE_MIN || vco_band > VCO_BAND_MAX;
  // sclk rises counted within one frame
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      n_q <= 5'h00;
      sk_q <= 1'b0;
    end
    else
    begin
      sk_q <= spi_sclk;
      n_q <= spi_cs_n ? 5'h00 : n_q + 5'(spi_sclk && !sk_q);
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sclk_idle_a:
    assert property (spi_cs_n |-> !spi_sclk) else $error("sclk off frame");
  frame_bits_a:
    assert property ($rose(spi_cs_n) |-> n_q == 5'h18)
    else $error("frame not 24 bits");
  sclk_high_a:
    assert property ($rose(spi_sclk) |-> spi_sclk [*4] ##1 !spi_sclk)
    else $error("sclk high phase wrong");
  sdo_hold_a:
    assert property (spi_sclk |-> $stable(spi_sdo))
    else $error("sdo moved while sclk high");
  cs_gap_a:
    assert property ($rose(spi_cs_n) |-> spi_cs_n [*2])
    else $error("frame gap short");
  ready_stat_a:
    assert property (ready |-> (pll_status & 8'he2) == 8'h22)
    else $error("ready without lock");
  cal_mirror_a:
    assert property ((cal_done == pll_status[ST_CAL_DONE]) &&
      (busy || ready || fail || !cal_done)) else $error("cal flag");
  idle_clear_a:
    assert property (!busy && !ready && !fail |-> pll_status == 8'h00)
    else $error("status kept while idle");
  bad_cfg_a:
    assert property (go && bad |=> cfg_error && !busy)
    else $error("bad setup taken");
  good_cfg_a:
    assert property (go && !bad |=> busy && !cfg_error)
    else $error("good setup refused");
endmodule : dpc_chk
bind dpc_pll_host dpc_chk dpc_chk_inst (.clock, .rst_n, .clk_en, .start,
  .prediv_code, .vco_postdivider_code, .feedback_loop_ratio, .vco_band,
  .busy, .ready, .fail, .cfg_error, .cal_done, .pll_status, .spi_sclk,
  .spi_cs_n, .spi_sdo);

/* File: verif/dpc_dev_model.sv */
`timescale 1ns/1ns
module dpc_dev_model
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdo,
  output logic spi_sdi,
  output logic irq_n,
  input wire logic edge_req,
  input wire logic lose_req
);
  logic [7:0] mem [0:511];
  logic [22:0] wlog [0:255];
  logic [23:0] sh;
  logic [14:0] a;
  logic [7:0] d, rd, st;
  logic [6:0] cal;
  logic [5:4] src;
  logic [4:0] cnt;
  logic sk, on, cp, edg;
  int wn;
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {cnt, sk, on, cp, edg, st, src, cal} = '0;
      wn = 0;
      mem[9'h01f] = 8'h00;
      mem[9'h083] = 8'h00;
      spi_sdi <= 1'b0;
      irq_n <= 1'b1;
    end
    else
    begin
      edg = edg | edge_req;
      if (lose_req && st[1])
      begin
        st[1] = 1'b0;
        src[5] = src[5] | mem[9'h01f][5];
        cal = 7'h40;
      end
      if (cal != 7'h00)
        cal = cal + 7'h01;
      if (cal == 7'h41)
      begin
        cal = 7'h00;
        cp = 1'b1;
        st = {edg, 2'h1, 3'h0, ~edg, 1'b0};
        src[4] = src[4] | (mem[9'h01f][4] & ~edg);
      end
      if (spi_cs_n)
        cnt = 5'h00;
      else if (spi_sclk && !sk)
      begin
        sh = {sh[22:0], spi_sdo};
        cnt = cnt + 5'h01;
        if (cnt == 5'h10)
          rd = sh[14:0] == 15'h0084 ? st :
            sh[14:0] == 15'h0023 ? {2'h0, src, 4'h0} : mem[sh[8:0]];
        if (cnt == 5'h18 && !sh[23])
        begin
          wlog[wn[7:0]] = sh[22:0];
          wn++;
          a = sh[22:8];
          d = sh[7:0];
          if (a == 15'h0023)
            src = src & ~d[5:4];
          if (a == 15'h0083 && !d[4])
            {on, st, cal} = '0;
          else if (a == 15'h0083 && (!on || d[7] && !mem[9'h083][7]))
          begin
            edg = edg & ~on;
            on = 1'b1;
            st = st & 8'h20;
            cal = cp ? 7'h40 : 7'h01;
          end
          if (a != 15'h0084)
            mem[a[8:0]] = d;
        end
      end
      else if (!spi_sclk && sk && cnt >= 5'h10)
      begin
        spi_sdi <= rd[7];
        rd = {rd[6:0], 1'b0};
      end
      if (spi_cs_n || cnt < 5'h10)
        spi_sdi <= ~spi_sdi;
      sk = spi_sclk;
      irq_n <= ~|src;
    end
  end
endmodule : dpc_dev_model

/* File: verif/testbench.sv */
`timescale 1ns/1ns
module testbench
  import dpc_pkg::*;
;
  logic clock, rst_n, clk_en, start, stop, irq_lock_en, irq_lost_en;
  logic [2:0] prediv_code;
  logic [1:0] vco_postdivider_code, vco_band, irq_events;
  logic [7:0] feedback_loop_ratio, pll_status;
  logic busy, ready, cal_done, fail, cfg_error;
  logic spi_sclk, spi_cs_n, spi_sdo, spi_sdi, irq_n, edge_req, lose_req;
  int failures, compares, cyc, base;
  logic [22:0] e [0:20];
  dpc_pll_host dpc_pll_host_inst (.clock, .rst_n, .clk_en, .start,
    .stop, .prediv_code, .vco_postdivider_code, .feedback_loop_ratio,
    .vco_band, .irq_lock_en, .irq_lost_en, .busy, .ready, .cal_done, .fail,
    .cfg_error, .pll_status, .irq_events, .spi_sclk, .spi_cs_n, .spi_sdo,
    .spi_sdi, .irq_n);
  dpc_dev_model dpc_dev_model_inst (.clock, .rst_n, .spi_sclk, .spi_cs_n,
    .spi_sdo, .spi_sdi, .irq_n, .edge_req, .lose_req);
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task end_sim();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      failures++;
      end_sim();
    end
  end
  task check(input logic [22:0] seen, input logic [22:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [22:0] lg(input int k);
    return dpc_dev_model_inst.wlog[k];
  endfunction : lg
  task pulse(input logic [14:0] c);
    {prediv_code, vco_postdivider_code, feedback_loop_ratio, vco_band} = c;
    start = 1'b1;
    @(negedge clock);
    start = 1'b0;
  endtask : pulse
  task t_reset();
    check(23'({busy, ready, spi_cs_n, pll_status}), 23'h100);
  endtask : t_reset
  task t_bad();
    logic [14:0] t [0:4] = '{15'h5040, 15'h0040, 15'h0414, 15'h0600,
      15'h0443};
    for (int i = 0; i < 5; i++)
    begin
      pulse(t[i]);
      @(negedge clock);
      check(23'({cfg_error, busy}), 23'h2);
    end
  endtask : t_bad
  task t_good(input int i);
    logic [7:0] r [0:4] = '{8'h06, 8'h7f, 8'h10, 8'h08, 8'h40};
    logic [1:0] o, b;
    o = 2'(1 + i % 3);
    b = 2'(i % 3);
    irq_lock_en = (i == 2);
    irq_lost_en = (i == 2);
    edge_req = (i == 1);
    base = dpc_dev_model_inst.wn;
    for (int k = 0; k < FIX_N; k++)
      e[k] = {FIX_ADDR[k], FIX_DATA[k]};
    e[13] = {ADDR_POSTDIV_SELECT, 6'h00, o};
    e[14] = {ADDR_FEEDBACK_RATIO, r[i]};
    e[15] = {ADDR_PREDIV_SELECT, 5'h00, 3'(i)};
    e[16] = {ADDR_VCO_CTL_A, VCO_A[b]};
    e[17] = {ADDR_VCO_CTL_B, VCO_B[b]};
    e[18] = {ADDR_VCO_CTL_C, VCO_C[b]};
    e[19] = {ADDR_IRQ_ENABLE, 2'h0, irq_lost_en, irq_lock_en, 4'h0};
    e[20] = {ADDR_PLL_CONTROL, CTL_ENABLE};
    pulse({3'(i), o, r[i], b});
    edge_req = 1'b0;
    if (i == 4)
    begin
      // frame just opened: a frozen clock enable must hold sclk low
      repeat (2) @(negedge clock);
      clk_en = 1'b0;
      repeat (6) @(negedge clock);
      check(23'({spi_cs_n, spi_sclk, busy}), 23'h1);
      clk_en = 1'b1;
    end
    for (int k = 0; k < 20000 && ready !== 1'b1; k++)
      @(negedge clock);
    check(23'({cal_done, pll_status}), 23'h122);
    for (int k = 0; k < 21; k++)
      check(lg(base + k), e[k]);
    if (i == 1)
    begin
      check(lg(base + 21), {ADDR_PLL_CONTROL, CTL_ENABLE});
      check(lg(base + 22), {ADDR_PLL_CONTROL, 8'h90});
    end
    if (i == 2)
    begin
      for (int k = 0; k < 2000 && irq_n !== 1'b1; k++)
        @(negedge clock);
      check(23'(irq_events), 23'h1);
      lose_req = 1'b1;
      @(negedge clock);
      lose_req = 1'b0;
      for (int k = 0; k < 2000 && irq_n !== 1'b1; k++)
        @(negedge clock);
      check(23'(irq_events), 23'h3);
      // stop is only taken once polling has settled in ready or fail
      for (int k = 0; k < 2000 && ready !== 1'b1; k++)
        @(negedge clock);
    end
    stop = 1'b1;
    @(negedge clock);
    stop = 1'b0;
    for (int k = 0; k < 2000 && (busy | ready | ~spi_cs_n) !== 1'b0; k++)
      @(negedge clock);
    check(lg(dpc_dev_model_inst.wn - 1), {ADDR_PLL_CONTROL, CTL_OFF});
    check(23'(pll_status), 23'h0);
  endtask : t_good
  initial
  begin
    {rst_n, start, stop, edge_req, lose_req, irq_lock_en, irq_lost_en} = '0;
    {prediv_code, vco_postdivider_code, feedback_loop_ratio, vco_band} = '0;
    clk_en = 1'b1;
    repeat (2) @(negedge clock);
    t_reset();
    rst_n = 1'b1;
    t_bad();
    for (int i = 0; i < 5; i++)
      t_good(i);
    end_sim();
  end
endmodule : testbench
